//--- pmc_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the power-mode controller.
// Assumes: A 32-bit APB register bus with one aligned word per register.
// Notes: Definitions only.
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Register byte offsets.
`define PMC_OFS_MODE 8'h00
`define PMC_OFS_PORTG 8'h04
`define PMC_OFS_IRQ 8'h08
`define PMC_OFS_STATUS 8'h0C

// Mode and idle-timer control layout.
`define PMC_MODE_RESET 8'h40
`define PMC_BIT_LOW_OSC_ON 7
`define PMC_BIT_HIGH_OSC_ON 6
`define PMC_BIT_TMR_CLK_SEL 5
`define PMC_BIT_CORE_CLK_SEL 4
`define PMC_WIN_W 3

// Port G control bits.
`define PMC_BIT_HALT_REQ 7
`define PMC_BIT_IDLE_REQ 6

// Interrupt control bits.
`define PMC_BIT_IRQ_EN 0
`define PMC_BIT_PENDING 1

// Legal patterns of the four mode bits.
`define PMC_MODE_HS 4'h4
`define PMC_MODE_HS_DC 4'hC
`define PMC_MODE_DC 4'hE
`define PMC_MODE_DC_LS 4'hF
`define PMC_MODE_LS 4'hB

// Timing: instruction clock is the high-speed clock divided by five.
`define PMC_INSTR_DIV 3'h5
`define PMC_TMR_W 17
`define PMC_STARTUP_LOAD 17'h00100
`define PMC_TAP_BASE 12
`define PMC_TAP_LAST 3'h4

`endif

//--- pmc_pkg.sv
// Purpose: Types shared by the power-mode controller modules.
// Assumes: pmc_defs.svh supplies the widths.
// Notes: State records are packed so that pmc_idle_timer registers one variable and pmc_ctrl one besides wake_cycles.
`include "pmc_defs.svh"

package pmc_pkg;

  // Operating state of the core clock sequencer.
  typedef enum logic [3:0] {
    PMC_RUN  = 4'b0001,
    PMC_HALT = 4'b0010,
    PMC_WAKE = 4'b0100,
    PMC_IDLE = 4'b1000
  } pmc_state_t;

  // All state of the controller.
  typedef struct packed {
    pmc_state_t state;
    logic [7:0] mode_idle_timer_ctrl;
    logic idle_timer_irq_enable;
    logic idle_timer_pending;
    logic halt_pend;
    logic idle_pend;
    logic [2:0] div_cnt;
    logic instr_tick;
    logic self_reset;
    logic [31:0] prdata;
  } pmc_regs_t;

  // All state of the idle timer.
  typedef struct packed {
    logic [`PMC_TMR_W-1:0] cnt;
    logic tap_prev;
    logic tap_toggle;
  } pmc_tmr_t;

endpackage

//--- pmc_idle_timer.sv
// Purpose: Free-running idle timer with window taps and the wake-up start-up load.
// Assumes: tick is a one-cycle enable already gated by clock source and amplitude.
// Notes: The count is not visible to software; it is exported only for sequencing.
`include "pmc_defs.svh"

module pmc_idle_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic load_startup,
  input wire logic [`PMC_WIN_W-1:0] window_sel,
  output logic [`PMC_TMR_W-1:0] count,
  output logic tap_toggle
);
  import pmc_pkg::*;

  pmc_tmr_t r;
  pmc_tmr_t next_r;

  // five window lengths
  // Window codes above the largest tap fall back to the longest window.
  function automatic logic tap_bit(input logic [`PMC_TMR_W-1:0] c,
                                   input logic [`PMC_WIN_W-1:0] sel);
    logic [`PMC_WIN_W-1:0] idx;
    idx = (sel > `PMC_TAP_LAST) ? `PMC_TAP_LAST : sel;
    return c[`PMC_TAP_BASE + int'(idx)];
  endfunction

  // Next-state logic; a changed window may report one spurious toggle.
  always_comb begin
    next_r = r;
    if (load_startup) begin
      next_r.cnt = `PMC_STARTUP_LOAD;
    end else if (tick) begin
      next_r.cnt = r.cnt - `PMC_TMR_W'(1);
    end
    next_r.tap_prev = tap_bit(r.cnt, window_sel);
    next_r.tap_toggle = tap_bit(r.cnt, window_sel) != r.tap_prev;
  end

  // The counter has no defined value for software; zero is used for determinism.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign count = r.cnt;
  assign tap_toggle = r.tap_toggle;

  a_startup_load: assert property (@(posedge pclk) disable iff (!presetn)
    load_startup |=> count == `PMC_STARTUP_LOAD)
    else $error("Start-up load of the idle timer missing.");

  a_timer_decrement: assert property (@(posedge pclk) disable iff (!presetn)
    tick && !load_startup |=> count == $past(count) - `PMC_TMR_W'(1))
    else $error("Idle timer did not decrement on its tick.");

endmodule

//--- pmc_ctrl.sv
// Purpose: Power-mode controller: clock modes, HALT, IDLE and idle-timer events over APB.
// Assumes: pclk is the high-speed clock; low_tick, wakeup and osc_qualified are synchronous.
// Notes: presetn is the external reset pin; self_reset asks the chip to reset itself.
//
// The address map and the APB register port were chosen for this implementation.
`include "pmc_defs.svh"

module pmc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_disable,
  input wire logic wakeup,
  input wire logic osc_qualified,
  input wire logic low_tick,
  output logic core_clk_en,
  output logic high_osc_on,
  output logic low_osc_on,
  output logic idle_timer_clk_sel,
  output logic core_clk_sel,
  output logic irq,
  output logic self_reset,
  output pmc_pkg::pmc_state_t power_state
);
  import pmc_pkg::*;

  pmc_regs_t r;
  pmc_regs_t next_r;
  logic tmr_tick;
  logic load_startup;
  logic tap_toggle;
  logic [`PMC_TMR_W-1:0] tmr_count;
  logic acc;
  logic wr;

  // Only the five documented mode patterns keep a core clock alive.
  function automatic logic mode_legal(input logic [3:0] m);
    case (m)
      `PMC_MODE_HS, `PMC_MODE_HS_DC, `PMC_MODE_DC, `PMC_MODE_DC_LS, `PMC_MODE_LS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == `PMC_OFS_MODE || a == `PMC_OFS_PORTG || a == `PMC_OFS_IRQ ||
           a == `PMC_OFS_STATUS;
  endfunction

  // Read view of the registers at one offset.
  function automatic logic [31:0] read_word(input pmc_regs_t s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h00000000;
    case (a)
      `PMC_OFS_MODE: d[7:0] = s.mode_idle_timer_ctrl;
      `PMC_OFS_PORTG: begin
        d[`PMC_BIT_HALT_REQ] = s.halt_pend;
        d[`PMC_BIT_IDLE_REQ] = s.idle_pend;
      end
      `PMC_OFS_IRQ: begin
        d[`PMC_BIT_IRQ_EN] = s.idle_timer_irq_enable;
        d[`PMC_BIT_PENDING] = s.idle_timer_pending;
      end
      `PMC_OFS_STATUS: d[3:0] = s.state;
      default: d = 32'h00000000;
    endcase
    return d;
  endfunction

  // APB: one wait-free access phase after the setup cycle that latches read data.
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign pready = acc;
  assign pslverr = acc && !mapped(paddr);

  // Timer clock source: the start-up delay always uses qualified instruction ticks.
  always_comb begin
    case (r.state)
      PMC_WAKE: tmr_tick = r.instr_tick && osc_qualified;
      PMC_HALT: tmr_tick = 1'b0;
      default: tmr_tick = r.mode_idle_timer_ctrl[`PMC_BIT_TMR_CLK_SEL] ? low_tick
                                                                       : r.instr_tick;
    endcase
  end

  assign load_startup = (r.state == PMC_HALT) && wakeup;

  pmc_idle_timer pmc_idle_timer_i (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tmr_tick),
    .load_startup(load_startup),
    .window_sel(r.mode_idle_timer_ctrl[`PMC_WIN_W-1:0]),
    .count(tmr_count),
    .tap_toggle(tap_toggle)
  );

  // Next-state logic: divider, register writes, power sequencer, pending flag.
  always_comb begin
    next_r = r;
    next_r.instr_tick = 1'b0;
    next_r.self_reset = 1'b0;
    if (r.div_cnt == `PMC_INSTR_DIV - 3'h1) begin
      next_r.div_cnt = 3'h0;
      next_r.instr_tick = 1'b1;
    end else begin
      next_r.div_cnt = r.div_cnt + 3'h1;
    end
    if (psel && !penable) begin
      next_r.prdata = read_word(r, paddr);
    end
    if (wr && paddr == `PMC_OFS_MODE) begin
      // Bit 3 is reserved and always stored as zero.
      next_r.mode_idle_timer_ctrl = {pwdata[7:4], 1'b0, pwdata[2:0]};
    end
    if (wr && paddr == `PMC_OFS_PORTG) begin
      if (pwdata[`PMC_BIT_HALT_REQ] && !halt_disable) begin
        next_r.halt_pend = 1'b1;
      end
      if (pwdata[`PMC_BIT_IDLE_REQ]) begin
        next_r.idle_pend = 1'b1;
      end
    end
    if (wr && paddr == `PMC_OFS_IRQ) begin
      next_r.idle_timer_irq_enable = pwdata[`PMC_BIT_IRQ_EN];
      if (!pwdata[`PMC_BIT_PENDING]) begin
        next_r.idle_timer_pending = 1'b0;
      end
    end
    case (r.state)
      PMC_RUN: begin
        if (r.halt_pend && r.instr_tick) begin
          next_r.state = PMC_HALT;
          next_r.halt_pend = 1'b0;
          next_r.idle_pend = 1'b0;
        end else if (r.idle_pend && r.instr_tick) begin
          next_r.state = PMC_IDLE;
          next_r.idle_pend = 1'b0;
        end
      end
      PMC_HALT: begin
        if (wakeup) begin
          next_r.state = PMC_WAKE;
        end
      end
      PMC_WAKE: begin
        if (tmr_tick && tmr_count == `PMC_TMR_W'(1)) begin
          next_r.state = PMC_RUN;
        end
      end
      PMC_IDLE: begin
        if (tap_toggle || wakeup) begin
          next_r.state = PMC_RUN;
        end
      end
      default: next_r.state = PMC_RUN;
    endcase
    if (tap_toggle && r.state != PMC_WAKE && r.state != PMC_HALT) begin
      next_r.idle_timer_pending = 1'b1;
    end
    if (!mode_legal(r.mode_idle_timer_ctrl[7:4])) begin
      next_r = '0;
      next_r.state = PMC_RUN;
      next_r.mode_idle_timer_ctrl = `PMC_MODE_RESET;
      next_r.self_reset = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.state <= PMC_RUN;
      r.mode_idle_timer_ctrl <= `PMC_MODE_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign core_clk_en = r.state == PMC_RUN;
  assign high_osc_on = r.mode_idle_timer_ctrl[`PMC_BIT_HIGH_OSC_ON] && r.state != PMC_HALT;
  assign low_osc_on = r.mode_idle_timer_ctrl[`PMC_BIT_LOW_OSC_ON];
  assign idle_timer_clk_sel = r.mode_idle_timer_ctrl[`PMC_BIT_TMR_CLK_SEL];
  assign core_clk_sel = r.mode_idle_timer_ctrl[`PMC_BIT_CORE_CLK_SEL];
  assign irq = r.idle_timer_pending && r.idle_timer_irq_enable;
  assign self_reset = r.self_reset;
  assign power_state = r.state;
  assign prdata = r.prdata;

  // Cycles spent in the start-up delay, for checking its length.
  logic [11:0] wake_cycles;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cycles <= 12'h000;
    end else if (r.state == PMC_WAKE) begin
      wake_cycles <= wake_cycles + 12'h001;
    end else begin
      wake_cycles <= 12'h000;
    end
  end

  sequence s_halt_entry;
    r.state == PMC_RUN && r.halt_pend && r.instr_tick;
  endsequence

  sequence s_wake_request;
    r.state == PMC_HALT && wakeup;
  endsequence

  a_reset_high_speed: assert property (@(posedge pclk)
    $rose(presetn) |-> r.state == PMC_RUN && r.mode_idle_timer_ctrl == `PMC_MODE_RESET)
    else $error("Reset did not start in high-speed mode.");

  a_halt_stops_clocks: assert property (@(posedge pclk) disable iff (!presetn)
    r.state == PMC_HALT |-> !core_clk_en && !high_osc_on)
    else $error("Clocks still running in HALT.");

  a_halt_entry: assert property (@(posedge pclk) disable iff (!presetn)
    s_halt_entry |=> r.state == PMC_HALT ##1 !core_clk_en)
    else $error("HALT not entered at the instruction tick.");

  a_halt_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `PMC_OFS_PORTG && halt_disable && !r.halt_pend |=> !r.halt_pend)
    else $error("HALT request accepted while disabled.");

  a_wake_startup: assert property (@(posedge pclk) disable iff (!presetn)
    s_wake_request |=> r.state == PMC_WAKE && tmr_count == `PMC_STARTUP_LOAD)
    else $error("Wake-up skipped the start-up delay.");

  a_startup_length: assert property (@(posedge pclk) disable iff (!presetn)
    r.state == PMC_WAKE ##1 r.state == PMC_RUN |-> $past(wake_cycles) >= 12'd1275)
    else $error("Start-up delay shorter than 256 instruction cycles.");

  a_unqualified_hold: assert property (@(posedge pclk) disable iff (!presetn)
    r.state == PMC_WAKE && !osc_qualified |=> $stable(tmr_count))
    else $error("Start-up count moved without oscillator amplitude.");

  a_idle_entry: assert property (@(posedge pclk) disable iff (!presetn)
    r.state == PMC_RUN && r.idle_pend && !r.halt_pend && r.instr_tick
    |=> r.state == PMC_IDLE && !core_clk_en &&
        high_osc_on == r.mode_idle_timer_ctrl[`PMC_BIT_HIGH_OSC_ON])
    else $error("IDLE not entered after request.");

  a_idle_window_exit: assert property (@(posedge pclk) disable iff (!presetn)
    r.state == PMC_IDLE && tap_toggle |=> r.state == PMC_RUN && r.idle_timer_pending)
    else $error("Window toggle did not end IDLE and set pending.");

  a_illegal_mode: assert property (@(posedge pclk) disable iff (!presetn)
    !mode_legal(r.mode_idle_timer_ctrl[7:4])
    |=> self_reset && r.mode_idle_timer_ctrl == `PMC_MODE_RESET)
    else $error("Illegal mode bits did not cause a self reset.");

endmodule

//--- pmc_osc_model.sv
// Purpose: Behavioural oscillators and wake-up source facing the power-mode controller.
// Assumes: Each oscillator settles a fixed number of pclk cycles after it is enabled.
// Notes: The low clock appears as a tick pulse; wakeup follows wake_req by one cycle.
module pmc_osc_model #(
  parameter int HS_START = 16,
  parameter int LS_START = 40,
  parameter int LS_DIV = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic high_osc_on,
  input wire logic low_osc_on,
  input wire logic wake_req,
  output logic osc_qualified,
  output logic low_stable,
  output logic low_tick,
  output logic wakeup
);
  timeunit 1ns;
  timeprecision 1ps;
  int hs_cnt;
  int ls_cnt;
  int div;

  // startup before stable
  // A stopped oscillator loses its amplitude at once, so every restart pays the full delay.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_cnt <= 0;
      ls_cnt <= 0;
      div <= 0;
      wakeup <= 1'b0;
    end else begin
      hs_cnt <= !high_osc_on ? 0 : (hs_cnt == HS_START) ? hs_cnt : hs_cnt + 1;
      ls_cnt <= !low_osc_on ? 0 : (ls_cnt == LS_START) ? ls_cnt : ls_cnt + 1;
      div <= (!low_stable || div == LS_DIV - 1) ? 0 : div + 1;
      wakeup <= wake_req;
    end
  end

  // Qualification flags and the divided low-speed tick.
  assign osc_qualified = (hs_cnt == HS_START);
  assign low_stable = (ls_cnt == LS_START);
  assign low_tick = low_stable && (div == LS_DIV - 1);
endmodule

//--- pmc_ctrl_tb.sv
// Purpose: Self-checking bench of the power-mode controller over APB.
// Assumes: pclk is the high-speed clock; the oscillator model answers the enables.
// Notes: Outputs except pready, prdata, pslverr and self_reset are sampled on the falling edge, after updates have landed; those four at the rising edge.
`include "pmc_defs.svh"
module pmc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmc_pkg::*;
  localparam int HS_START = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, halt_disable, wakeup;
  logic osc_qualified, low_tick, low_stable, core_clk_en, high_osc_on, low_osc_on;
  logic idle_timer_clk_sel, core_clk_sel, irq, self_reset, wake_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  pmc_state_t power_state;
  int errors = 0;
  int n_tests = 0;
  int n_sr = 0;
  int n;
  time prev_irq, last_irq;
  logic [7:0] seq [8] = '{8'hC0, 8'hE0, 8'hF0, 8'hB0, 8'hF0, 8'hE0, 8'hC0, 8'h40};

  pmc_ctrl pmc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_disable(halt_disable), .wakeup(wakeup),
    .osc_qualified(osc_qualified), .low_tick(low_tick), .core_clk_en(core_clk_en),
    .high_osc_on(high_osc_on), .low_osc_on(low_osc_on), .idle_timer_clk_sel(idle_timer_clk_sel),
    .core_clk_sel(core_clk_sel), .irq(irq), .self_reset(self_reset), .power_state(power_state));
  pmc_osc_model #(.HS_START(HS_START)) pmc_osc_model_i (.pclk(pclk), .presetn(presetn),
    .high_osc_on(high_osc_on), .low_osc_on(low_osc_on), .wake_req(wake_req),
    .osc_qualified(osc_qualified), .low_stable(low_stable), .low_tick(low_tick),
    .wakeup(wakeup));

  // Free-running clock at 50 MHz.
  always #10 pclk = ~pclk;

  // Count self-reset pulses and time-stamp rising interrupt levels.
  always @(posedge pclk) if (self_reset === 1'b1) n_sr++;
  always @(posedge irq) begin
    prev_irq = last_irq;
    last_irq = $time;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      errors++;
      $display("mismatch at %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, wd, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  task automatic wait_st(input pmc_state_t s, output int cyc);
    cyc = 0;
    while (power_state !== s) begin
      @(negedge pclk);
      cyc++;
    end
  endtask

  // Software waits for whichever oscillators are enabled before the next step.
  task automatic wait_osc;
    while (!((low_osc_on !== 1'b1 || low_stable) && (high_osc_on !== 1'b1 || osc_qualified)))
      @(negedge pclk);
  endtask

  task automatic pulse_wake;
    @(posedge pclk);
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic end_sim;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // A hang is cut short well beyond the expected run of about 43k cycles.
  initial begin
    #1600000;
    errors++;
    end_sim();
  end

  // Main sequence.
  initial begin
    logic e;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, halt_disable, wake_req} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    rd_chk(`PMC_OFS_MODE, 32'h40);
    rd_chk(`PMC_OFS_STATUS, 32'h1);
    chk({28'h0, low_osc_on, high_osc_on, idle_timer_clk_sel, core_clk_sel}, 32'h4);
    apb(1'b0, 8'h10, 32'h0, d, e);
    chk({d[30:0], e}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(`PMC_OFS_MODE, {24'h0, seq[i]});
      wait_osc();
      rd_chk(`PMC_OFS_MODE, {24'h0, seq[i]});
      chk({28'h0, low_osc_on, high_osc_on, idle_timer_clk_sel, core_clk_sel},
          {28'h0, seq[i][7:4]});
    end
    $display("test modes done");
    @(posedge pclk);
    halt_disable <= 1'b1;
    wr(`PMC_OFS_PORTG, 32'h80);
    repeat (12) @(negedge pclk);
    chk({28'h0, power_state}, 32'h1);
    rd_chk(`PMC_OFS_PORTG, 32'h0);
    @(posedge pclk);
    halt_disable <= 1'b0;
    $display("test halt disable done");
    wr(`PMC_OFS_PORTG, 32'h80);
    wait_st(PMC_HALT, n);
    chk_rng(n, 0, 7);
    chk({30'h0, core_clk_en, high_osc_on}, 32'h0);
    pulse_wake();
    wait_st(PMC_WAKE, n);
    chk_rng(n, 0, 2);
    wait_st(PMC_RUN, n);
    chk_rng(n, 1276, 1276 + HS_START + 8);
    $display("test halt wake done");
    wr(`PMC_OFS_PORTG, 32'h80);
    wait_st(PMC_HALT, n);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({28'h0, power_state}, 32'h1);
    rd_chk(`PMC_OFS_MODE, 32'h40);
    $display("test halt reset done");
    wait_osc();
    wr(`PMC_OFS_IRQ, 32'h1);
    wr(`PMC_OFS_PORTG, 32'h40);
    wait_st(PMC_IDLE, n);
    chk({30'h0, core_clk_en, high_osc_on}, 32'h1);
    wait_st(PMC_RUN, n);
    chk({31'h0, irq}, 32'h1);
    rd_chk(`PMC_OFS_IRQ, 32'h3);
    wr(`PMC_OFS_IRQ, 32'h1);
    while (irq !== 1'b1) @(negedge pclk);
    chk(32'((last_irq - prev_irq) / 20), 32'd20480);
    $display("test idle window done");
    wr(`PMC_OFS_IRQ, 32'h1);
    wr(`PMC_OFS_PORTG, 32'h40);
    wait_st(PMC_IDLE, n);
    pulse_wake();
    wait_st(PMC_RUN, n);
    chk_rng(n, 0, 3);
    $display("test idle wake done");
    wr(`PMC_OFS_IRQ, 32'h0);
    wr(`PMC_OFS_MODE, 32'h41);
    wr(`PMC_OFS_IRQ, 32'h0);
    rd_chk(`PMC_OFS_MODE, 32'h41);
    rd_chk(`PMC_OFS_IRQ, 32'h0);
    $display("test window select done");
    wr(`PMC_OFS_MODE, 32'h80);
    repeat (3) @(negedge pclk);
    chk(32'(n_sr), 32'h1);
    rd_chk(`PMC_OFS_MODE, 32'h40);
    $display("test illegal mode done");
    end_sim();
  end
endmodule
